// ===== lbc_buf_if.sv
// Valid/ready stream carrier between the main loopback module and its buffer.
// Assumes one clock domain.
`timescale 1ns/1ps
interface lbc_buf_if;
	logic        valid;
	logic        ready;
	logic [1:0]  data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : lbc_buf_if

// ===== lbc_line_model.sv
// Line-side and backplane model facing the loopback block.
// Assumes its outputs change only at the falling clock edge.
`timescale 1ns/1ps
module lbc_line_model (
	input  wire logic       core_clk_i,
	input  wire logic       stall_i,
	input  wire logic       pin_i,
	input  wire logic       slot_i,
	input  wire logic [6:0] chan_i,
	output logic            cdr_o,
	output logic            pin_o,
	output logic            store_o,
	output logic            chd_o,
	output logic            pcm_o,
	output logic            sig_o,
	output logic            slot_o,
	output logic [6:0]      idx_o,
	output logic            align_o,
	output logic            pulse_o,
	output logic            rzp_o,
	output logic            rzn_o,
	output logic            nrz_o,
	output logic            ready_o
);
	// ----
	// Toggling line traffic, fixed payload levels
	// ----
	logic [7:0] cnt = 8'h00;
	always @(negedge core_clk_i) cnt <= cnt + 8'h01;
	assign cdr_o   = cnt[0];
	assign pin_o   = pin_i;
	assign store_o = 1'b1;
	assign chd_o   = 1'b1;
	assign pcm_o   = 1'b0;
	assign sig_o   = 1'b0;
	assign slot_o  = slot_i;
	assign idx_o   = chan_i;
	assign align_o = cnt[1];
	assign pulse_o = cnt[2];
	assign rzp_o   = cnt[1];
	assign rzn_o   = ~cnt[1];
	assign nrz_o   = cnt[2];
	// Slow receiver: one stall in eight beside the commanded one
	assign ready_o = !stall_i && cnt[2:0] != 3'h7;
endmodule : lbc_line_model

// ===== lbc_loopback.sv
// Loopback routing and transmit per-channel controller access.
// Assumes a synchronous byte register port on core_clk_i; line pins arrive from outside.
//
// Function
// - Line loopback sends recovered data to transmit attenuator
// - Analog line loopback uses clock recovery output
// - Digital line loopback uses sampled receive data
// - Payload loopback feeds receive store into transmitter
// - Store read on transmit clock, transmit frame alignment
// - Frame alignment arbitrary, or backplane pulse when bypassed
// - Signaling insertion overwrites looped data, no superframe alignment
// - Digital loopback returns attenuator output to receiver
// - Analog dual-rail to recovery, digital NRZ to attenuator
// - Selected transmit channels replaced by receive channels
// - Reset selects direct mode; software sets indirect
// - Busy high while indirect access is processed
// - Busy rises right after address write, holds
`timescale 1ns/1ps
`include "lbc_map.svh"
module lbc_loopback (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       cdr_data_i,
	input  wire logic       digital_rx_data_in_i,
	input  wire logic       rx_store_data_i,
	input  wire logic       rx_chan_data_i,
	input  wire logic       tx_pcm_data_i,
	input  wire logic       tx_sig_data_i,
	input  wire logic       tx_sig_slot_i,
	input  wire logic [6:0] tx_chan_idx_i,
	input  wire logic       tx_frame_align_i,
	input  wire logic       backplane_tx_frame_pulse_i,
	input  wire logic       tx_jitter_attenuator_rz_pos_i,
	input  wire logic       tx_jitter_attenuator_rz_neg_i,
	input  wire logic       tx_jitter_attenuator_nrz_i,
	input  wire logic       tx_data_ready_i,
	output logic            tx_jitter_attenuator_data_o,
	output logic            tx_block_pcm_o,
	output logic            tx_block_valid_o,
	output logic            rx_store_read_clk_sel_o,
	output logic            rx_store_frame_align_o,
	output logic            cdr_pos_o,
	output logic            cdr_neg_o,
	output logic            cdr_loop_sel_o,
	output logic            rx_jitter_attenuator_data_o,
	output logic            rx_jitter_attenuator_loop_sel_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	lbc_pkg::lbc_byte_t diag;
	lbc_pkg::lbc_byte_t chcfg;
	lbc_pkg::lbc_byte_t mode;
	lbc_pkg::lbc_byte_t chaddr;
	lbc_pkg::lbc_byte_t chdata;
	logic               line_loop_enable;
	logic               payload_loop_enable;
	logic               diag_digital_loop_enable;
	logic               rx_unipolar_select;
	logic               channel_output_enable;
	logic               busy;
	logic               digital_rx_data_in_s1;
	logic               digital_rx_data_in_s2;
	logic               digital_rx_data_in_s3;
	logic               digital_rx_data_in_q;
	logic               next_tx_pcm;
	logic               chan_loop;
	logic               addr_wr;

	assign line_loop_enable         = diag[`LBC_DIAG_LINE_BIT];
	assign payload_loop_enable      = diag[`LBC_DIAG_PAY_BIT];
	assign diag_digital_loop_enable = diag[`LBC_DIAG_DIAG_DIGITAL_LOOP_ENABLE_BIT];
	assign rx_unipolar_select       = mode[`LBC_MODE_RX_UNIPOLAR_SELECT_BIT];
	assign channel_output_enable    = chcfg[`LBC_CFG_OE_BIT];
	assign addr_wr = reg_wr_i && (reg_addr_i == `LBC_OFS_CHADDR) && !busy;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			diag <= `LBC_DIAG_RST;
			chcfg <= `LBC_CFG_RST;
			mode <= `LBC_MODE_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `LBC_OFS_DIAG)
				diag <= reg_wdata_i;
			if (reg_addr_i == `LBC_OFS_CHCFG)
				chcfg <= {6'h00, reg_wdata_i[1:0]};
			if (reg_addr_i == `LBC_OFS_MODE)
				mode <= {2'h0, reg_wdata_i[5:0]};
		end
	end

	// ----------------------------------------
	// Per-channel controller, indirect access
	// ----------------------------------------
	// Only indirect mode is served; direct mode accesses are not decoded.
	logic [7:0] ch_mem [`LBC_CH_LOCS];
	lbc_pkg::lbc_acc_e acc_state;
	logic [1:0]        acc_cnt;
	logic              acc_hit;
	assign acc_hit = (chaddr[6:0] < 7'(`LBC_CH_LOCS));

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_state <= lbc_pkg::LBC_IDLE;
			acc_cnt <= 2'h0;
			busy <= 1'b0;
			chaddr <= 8'h00;
		end else begin
			unique case (acc_state)
				lbc_pkg::LBC_IDLE: begin
					if (addr_wr && chcfg[`LBC_CFG_IND_BIT]) begin
						chaddr <= reg_wdata_i;
						busy <= 1'b1;
						acc_cnt <= `LBC_ACC_CYC;
						acc_state <= lbc_pkg::LBC_WAIT;
					end
				end
				lbc_pkg::LBC_WAIT: begin
					acc_cnt <= acc_cnt - 2'h1;
					if (acc_cnt == 2'h1)
						acc_state <= lbc_pkg::LBC_DONE;
				end
				lbc_pkg::LBC_DONE: begin
					busy <= 1'b0;
					acc_state <= lbc_pkg::LBC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (acc_state == lbc_pkg::LBC_DONE && acc_hit && !chaddr[`LBC_ADDR_RNW_BIT])
			ch_mem[chaddr[6:0]] <= chdata;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			chdata <= 8'h00;
		else if (acc_state == lbc_pkg::LBC_DONE && chaddr[`LBC_ADDR_RNW_BIT])
			chdata <= acc_hit ? ch_mem[chaddr[6:0]] : 8'h00;
		else if (reg_wr_i && reg_addr_i == `LBC_OFS_CHDATA && !busy)
			chdata <= reg_wdata_i;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`LBC_OFS_DIAG:   reg_rdata_o <= diag;
				`LBC_OFS_CHCFG:  reg_rdata_o <= chcfg;
				`LBC_OFS_CHSTAT: reg_rdata_o <= {7'h00, busy};
				`LBC_OFS_CHADDR: reg_rdata_o <= chaddr;
				`LBC_OFS_CHDATA: reg_rdata_o <= chdata;
				`LBC_OFS_MODE:   reg_rdata_o <= mode;
				default:         reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Line loopback
	// ----------------------------------------
	// Receive pin is foreign; three stages, change taken when two agree.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			digital_rx_data_in_s1 <= 1'b0;
			digital_rx_data_in_s2 <= 1'b0;
			digital_rx_data_in_s3 <= 1'b0;
			digital_rx_data_in_q <= 1'b0;
		end else begin
			digital_rx_data_in_s1 <= digital_rx_data_in_i;
			digital_rx_data_in_s2 <= digital_rx_data_in_s1;
			digital_rx_data_in_s3 <= digital_rx_data_in_s2;
			if (digital_rx_data_in_s2 == digital_rx_data_in_s3)
				digital_rx_data_in_q <= digital_rx_data_in_s3;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			tx_jitter_attenuator_data_o <= 1'b0;
		else if (!line_loop_enable)
			tx_jitter_attenuator_data_o <= tx_pcm_data_i;
		else if (rx_unipolar_select)
			tx_jitter_attenuator_data_o <= digital_rx_data_in_q;
		else
			tx_jitter_attenuator_data_o <= cdr_data_i;
	end

	// ----------------------------------------
	// Payload and per-channel loopback
	// ----------------------------------------
	assign chan_loop = channel_output_enable && mode[`LBC_MODE_BYP_BIT]
		&& !mode[`LBC_MODE_BACKPLANE_CLOCK_MODE_BIT] && (tx_chan_idx_i < 7'(`LBC_CH_LOCS))
		&& ch_mem[tx_chan_idx_i][`LBC_DATA_LOOP_BIT];

	always_comb begin
		next_tx_pcm = tx_pcm_data_i;
		if (payload_loop_enable)
			next_tx_pcm = rx_store_data_i;
		else if (chan_loop)
			next_tx_pcm = rx_chan_data_i;
		if (mode[`LBC_MODE_SIG_BIT] && tx_sig_slot_i)
			next_tx_pcm = tx_sig_data_i;
	end

	assign rx_store_read_clk_sel_o = payload_loop_enable;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			rx_store_frame_align_o <= 1'b0;
		else if (mode[`LBC_MODE_TXES_BIT])
			rx_store_frame_align_o <= tx_frame_align_i;
		else
			rx_store_frame_align_o <= backplane_tx_frame_pulse_i;
	end

	// Buffer keeps a word when the transmitter stalls.
	lbc_buf_if buf_in ();
	lbc_buf_if buf_out ();
	assign buf_in.valid = 1'b1;
	assign buf_in.data  = {1'b0, next_tx_pcm};
	assign buf_out.ready = tx_data_ready_i;
	assign tx_block_valid_o = buf_out.valid;
	assign tx_block_pcm_o   = buf_out.data[0];

	lbc_skid_buf u_buf (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.in_bus     (buf_in.snk),
		.out_bus    (buf_out.src)
	);

	// ----------------------------------------
	// Diagnostic digital loopback
	// ----------------------------------------
	assign cdr_loop_sel_o  = diag_digital_loop_enable && !rx_unipolar_select;
	assign rx_jitter_attenuator_loop_sel_o = diag_digital_loop_enable && rx_unipolar_select;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cdr_pos_o <= 1'b0;
			cdr_neg_o <= 1'b0;
			rx_jitter_attenuator_data_o <= 1'b0;
		end else begin
			cdr_pos_o <= cdr_loop_sel_o & tx_jitter_attenuator_rz_pos_i;
			cdr_neg_o <= cdr_loop_sel_o & tx_jitter_attenuator_rz_neg_i;
			rx_jitter_attenuator_data_o <= rx_jitter_attenuator_loop_sel_o & tx_jitter_attenuator_nrz_i;
		end
	end
endmodule : lbc_loopback

// ===== lbc_loopback_chk.sv
// Concurrent checks on the loopback block top ports.
// Assumes bind onto lbc_loopback; one clock, async active-high reset.
`timescale 1ns/1ps
`include "lbc_map.svh"
module lbc_loopback_chk (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        cdr_data_i,
	input wire logic        tx_pcm_data_i,
	input wire logic        tx_frame_align_i,
	input wire logic        backplane_tx_frame_pulse_i,
	input wire logic        tx_jitter_attenuator_rz_pos_i,
	input wire logic        tx_jitter_attenuator_rz_neg_i,
	input wire logic        tx_jitter_attenuator_nrz_i,
	input wire logic        tx_data_ready_i,
	input wire logic        tx_jitter_attenuator_data_o,
	input wire logic        tx_block_pcm_o,
	input wire logic        tx_block_valid_o,
	input wire logic        rx_store_read_clk_sel_o,
	input wire logic        rx_store_frame_align_o,
	input wire logic        cdr_pos_o,
	input wire logic        cdr_neg_o,
	input wire logic        cdr_loop_sel_o,
	input wire logic        rx_jitter_attenuator_data_o,
	input wire logic        rx_jitter_attenuator_loop_sel_o
);
	// ----
	// Shadow state
	// ----
	logic [7:0] diag_q;
	logic [7:0] mode_q;
	logic       ind_q;
	logic [2:0] busy_cnt;
	wire        busy_h = busy_cnt != 3'h0;
	wire        align_src = mode_q[5] ? tx_frame_align_i : backplane_tx_frame_pulse_i;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			diag_q <= `LBC_DIAG_RST;
			mode_q <= `LBC_MODE_RST;
			ind_q  <= 1'b0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `LBC_OFS_DIAG) diag_q <= reg_wdata_i;
			if (reg_addr_i == `LBC_OFS_MODE) mode_q <= reg_wdata_i;
			if (reg_addr_i == `LBC_OFS_CHCFG) ind_q <= reg_wdata_i[`LBC_CFG_IND_BIT];
		end
	end
	// Busy spans the wait count plus the finishing cycle; a write while busy must not restart it
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			busy_cnt <= 3'h0;
		else if (reg_wr_i && reg_addr_i == `LBC_OFS_CHADDR && ind_q && !busy_h)
			busy_cnt <= 3'(`LBC_ACC_CYC) + 3'h1;
		else if (busy_h)
			busy_cnt <= busy_cnt - 3'h1;
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_status_read;
		reg_rd_i && reg_addr_i == `LBC_OFS_CHSTAT;
	endsequence
	sequence s_diag_read;
		reg_rd_i && reg_addr_i == `LBC_OFS_DIAG;
	endsequence
	chk_busy_status: assert property (s_status_read |=> reg_rdata_o[0] == $past(busy_h))
		else $error("busy status wrong");
	chk_diag_readback: assert property (s_diag_read |=> reg_rdata_o == $past(diag_q))
		else $error("diagnostics readback wrong");
	chk_line_cdr: assert property (diag_q[1] && !mode_q[0] |=> tx_jitter_attenuator_data_o == $past(cdr_data_i))
		else $error("line loop data wrong");
	chk_line_off: assert property (!diag_q[1] |=> tx_jitter_attenuator_data_o == $past(tx_pcm_data_i))
		else $error("attenuator data not from transmit path");
	chk_payload_clk: assert property (rx_store_read_clk_sel_o == diag_q[2])
		else $error("store read clock select wrong");
	chk_frame_align: assert property (diag_q[2] |=> rx_store_frame_align_o == $past(align_src))
		else $error("store frame alignment wrong");
	chk_diag_digital_loop_enable_analog: assert property (diag_q[0] && !mode_q[0] |-> cdr_loop_sel_o ##1 cdr_pos_o == $past(tx_jitter_attenuator_rz_pos_i))
		else $error("analog digital loop wrong");
	chk_diag_digital_loop_enable_neg_rail: assert property (diag_q[0] && !mode_q[0] |=> cdr_neg_o == $past(tx_jitter_attenuator_rz_neg_i))
		else $error("analog digital loop negative rail wrong");
	chk_diag_digital_loop_enable_digital: assert property (diag_q[0] && mode_q[0] |-> rx_jitter_attenuator_loop_sel_o ##1 rx_jitter_attenuator_data_o == $past(tx_jitter_attenuator_nrz_i))
		else $error("digital loop wrong");
	chk_stall_hold: assert property (tx_block_valid_o && !tx_data_ready_i |=> tx_block_valid_o && $stable(tx_block_pcm_o))
		else $error("stalled word lost");
endmodule : lbc_loopback_chk
bind lbc_loopback lbc_loopback_chk u_chk (.*);

// ===== lbc_map.svh
// Register offsets, field positions, reset values and sizes for the loopback block.
// Assumes inclusion by bare name from the loopback module, the checker and the bench.
`ifndef LBC_MAP_SVH
`define LBC_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LBC_ADDR_W          12
`define LBC_OFS_DIAG        12'h00A
`define LBC_OFS_CHCFG       12'h0E0
`define LBC_OFS_CHSTAT      12'h0E1
`define LBC_OFS_CHADDR      12'h0E2
`define LBC_OFS_CHDATA      12'h0E3
`define LBC_OFS_MODE        12'h0E4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LBC_DIAG_DIAG_DIGITAL_LOOP_ENABLE_BIT   0
`define LBC_DIAG_LINE_BIT   1
`define LBC_DIAG_PAY_BIT    2
`define LBC_CFG_OE_BIT      0
`define LBC_CFG_IND_BIT     1
`define LBC_MODE_RX_UNIPOLAR_SELECT_BIT   0
`define LBC_MODE_TX_UNIPOLAR_SELECT_BIT   1
`define LBC_MODE_BYP_BIT    2
`define LBC_MODE_BACKPLANE_CLOCK_MODE_BIT  3
`define LBC_MODE_SIG_BIT    4
`define LBC_MODE_TXES_BIT   5
`define LBC_ADDR_RNW_BIT    7
`define LBC_DATA_LOOP_BIT   0
// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define LBC_DIAG_RST        8'h00
`define LBC_CFG_RST         8'h00
`define LBC_MODE_RST        8'h00
`define LBC_CH_LOCS         96
`define LBC_CH_AW           7
`define LBC_ACC_CYC         2'h2
`endif

// ===== lbc_pkg.sv
// Types shared by the loopback block modules.
// Assumes lbc_map.svh is on the include path.
package lbc_pkg;
	typedef enum logic [1:0] {LBC_IDLE, LBC_WAIT, LBC_DONE} lbc_acc_e;
	typedef logic [7:0] lbc_byte_t;
endpackage : lbc_pkg

// ===== lbc_skid_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both ends on core_clk_i.
`timescale 1ns/1ps
module lbc_skid_buf (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	lbc_buf_if.snk    in_bus,
	lbc_buf_if.src    out_bus
);
	logic [1:0] mem [2];
	logic       wptr;
	logic       rptr;
	logic [1:0] count;

	assign in_bus.ready  = (count != 2'h2);
	assign out_bus.valid = (count != 2'h0);
	assign out_bus.data  = mem[rptr];

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr <= 1'b0;
			rptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (in_bus.valid && in_bus.ready)
				wptr <= ~wptr;
			if (out_bus.valid && out_bus.ready)
				rptr <= ~rptr;
			count <= count + {1'b0, in_bus.valid && in_bus.ready}
				- {1'b0, out_bus.valid && out_bus.ready};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (in_bus.valid && in_bus.ready)
			mem[wptr] <= in_bus.data;
	end
endmodule : lbc_skid_buf

// ===== tb.sv
// Self-checking bench for the loopback block.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`include "lbc_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
	logic core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, stall = 0, pin = 0, slot = 0;
	logic [11:0] reg_addr_i = 12'h000;
	logic [7:0]  reg_wdata_i = 8'h00, rd_q;
	logic [6:0]  chan = 7'h00;
	wire  [7:0]  rdata;
	wire  [6:0]  idx;
	wire cdr, pin_s, store, chd, pcm, sig, slt, fal, bpp, rzp, rzn, nrz, rdy;
	wire tjo, bpcm, bval, rsel, ralign, cpos, cneg, csel, rjd, rjsel;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	initial forever #5 core_clk_i = ~core_clk_i;
	lbc_line_model u_line (.core_clk_i(core_clk_i), .stall_i(stall), .pin_i(pin), .slot_i(slot),
		.chan_i(chan), .cdr_o(cdr), .pin_o(pin_s), .store_o(store), .chd_o(chd), .pcm_o(pcm),
		.sig_o(sig), .slot_o(slt), .idx_o(idx), .align_o(fal), .pulse_o(bpp), .rzp_o(rzp),
		.rzn_o(rzn), .nrz_o(nrz), .ready_o(rdy));
	lbc_loopback u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(rdata), .cdr_data_i(cdr), .digital_rx_data_in_i(pin_s),
		.rx_store_data_i(store), .rx_chan_data_i(chd), .tx_pcm_data_i(pcm), .tx_sig_data_i(sig),
		.tx_sig_slot_i(slt), .tx_chan_idx_i(idx), .tx_frame_align_i(fal),
		.backplane_tx_frame_pulse_i(bpp), .tx_jitter_attenuator_rz_pos_i(rzp), .tx_jitter_attenuator_rz_neg_i(rzn),
		.tx_jitter_attenuator_nrz_i(nrz), .tx_data_ready_i(rdy), .tx_jitter_attenuator_data_o(tjo),
		.tx_block_pcm_o(bpcm), .tx_block_valid_o(bval), .rx_store_read_clk_sel_o(rsel),
		.rx_store_frame_align_o(ralign), .cdr_pos_o(cpos), .cdr_neg_o(cneg),
		.cdr_loop_sel_o(csel), .rx_jitter_attenuator_data_o(rjd), .rx_jitter_attenuator_loop_sel_o(rjsel));
	// ----
	// Register access and checks
	// ----
	task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		reg_addr_i  = a;
		reg_wdata_i = d;
		reg_wr_i    = 1'b1;
		@(negedge core_clk_i);
		reg_wr_i = 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
		@(negedge core_clk_i);
		reg_addr_i = a;
		reg_rd_i   = 1'b1;
		@(negedge core_clk_i);
		reg_rd_i = 1'b0;
		d        = rdata;
	endtask : reg_read
	task automatic wait_idle();
		logic [7:0] s;
		s = 8'h01;
		for (int i = 0; i < 20 && s[0] !== 1'b0; i++)
			reg_read(`LBC_OFS_CHSTAT, s);
		`CHK("busy", 1'b0, s[0])
	endtask : wait_idle
	task automatic check_reg(input logic [11:0] a, input logic [7:0] e);
		reg_read(a, rd_q);
		`CHK("register", e, rd_q)
	endtask : check_reg
	task automatic stream_chk(input logic [6:0] ch, input logic e);
		chan = ch;
		repeat (10) @(negedge core_clk_i);
		`CHK("stream valid", 1'b1, bval)
		`CHK("stream data", e, bpcm)
	endtask : stream_chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// Generous ceiling: the full run needs about a thousand cycles
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		repeat (20) @(negedge core_clk_i);
		rst_i = 1'b0;
		check_reg(`LBC_OFS_CHCFG, 8'h00);
		check_reg(`LBC_OFS_MODE, 8'h00);
		check_reg(12'h0FF, 8'h00);
		reg_write(`LBC_OFS_CHADDR, 8'h85);
		check_reg(`LBC_OFS_CHSTAT, 8'h00);
		reg_write(`LBC_OFS_CHCFG, 8'h02);
		for (int c = 0; c < `LBC_CH_LOCS; c++) begin
			wait_idle();
			reg_write(`LBC_OFS_CHDATA, {7'h00, c == 5});
			reg_write(`LBC_OFS_CHADDR, {1'b0, c[6:0]});
		end
		wait_idle();
		reg_write(`LBC_OFS_CHADDR, 8'h86);
		check_reg(`LBC_OFS_CHSTAT, 8'h01);
		wait_idle();
		reg_read(`LBC_OFS_CHDATA, rd_q);
		`CHK("loop bit 6", 1'b0, rd_q[0])
		reg_write(`LBC_OFS_CHADDR, 8'h85);
		// Second address lands while busy and must be dropped
		reg_write(`LBC_OFS_CHADDR, 8'h86);
		wait_idle();
		reg_read(`LBC_OFS_CHDATA, rd_q);
		`CHK("loop bit 5", 1'b1, rd_q[0])
		reg_write(`LBC_OFS_MODE, 8'h04);
		reg_write(`LBC_OFS_CHCFG, 8'h03);
		stream_chk(7'h05, 1'b1);
		stream_chk(7'h06, 1'b0);
		reg_write(`LBC_OFS_DIAG, 8'h04);
		check_reg(`LBC_OFS_DIAG, 8'h04);
		stream_chk(7'h06, 1'b1);
		stall = 1'b1;
		stream_chk(7'h06, 1'b1);
		reg_write(`LBC_OFS_DIAG, 8'h00);
		stream_chk(7'h06, 1'b1);
		stall = 1'b0;
		stream_chk(7'h06, 1'b0);
		reg_write(`LBC_OFS_DIAG, 8'h04);
		reg_write(`LBC_OFS_MODE, 8'h34);
		slot = 1'b1;
		stream_chk(7'h06, 1'b0);
		slot = 1'b0;
		reg_write(`LBC_OFS_MODE, 8'h00);
		reg_write(`LBC_OFS_DIAG, 8'h02);
		repeat (20) @(negedge core_clk_i);
		reg_write(`LBC_OFS_MODE, 8'h01);
		for (int v = 1; v >= 0; v--) begin
			pin = v[0];
			repeat (8) @(negedge core_clk_i);
			`CHK("line loop pin", v[0], tjo)
		end
		reg_write(`LBC_OFS_MODE, 8'h03);
		reg_write(`LBC_OFS_DIAG, 8'h01);
		repeat (10) @(negedge core_clk_i);
		`CHK("rx_jitter_attenuator select", 1'b1, rjsel)
		reg_write(`LBC_OFS_MODE, 8'h00);
		repeat (10) @(negedge core_clk_i);
		`CHK("cdr select", 1'b1, csel)
		print_verdict();
	end
endmodule : tb
